// ### verilog/hbp_host_port.sv
module hbp_host_port
    import hbp_pkg::*;
(
    input  wire logic              clk,                  // System clock, 100 MHz.
    input  wire logic              rst_b,                // Asynchronous reset, active low.
    input  wire logic [15:0]       controlStatusZero,    // Control/status word zero.
    input  wire logic [15:0]       controlStatusFour,    // Control/status word four.
    input  wire hbp_flags_t        statusFlags,          // Interrupt source flags.
    input  wire logic              dmaReq,               // Core requests a master transfer.
    input  wire hbp_req_t          dmaCmd,               // Transfer described by the core.
    output logic                   dmaReady,             // Request taken this cycle.
    output logic                   dmaDone,              // Transfer finished, one cycle.
    output logic [DATA_W-1:0]      dmaRdData,            // Word read as master.
    output logic                   burstCut,             // Burst ended by release, one cycle.
    input  wire logic              slaveSel,             // Device addressed as slave.
    input  wire logic [DATA_W-1:0] slaveRdData,          // Word to return as slave.
    output logic                   slaveWrStrobe,        // Slave write captured, one cycle.
    output logic [DATA_W-1:0]      slaveWrData,          // Word captured as slave.
    input  wire logic [DATA_W-1:0] muxedAddrDataBusIn,   // Shared bus level.
    output logic [DATA_W-1:0]      muxedAddrDataBusOut,  // Shared bus drive value.
    output logic                   muxedAddrDataBusOe,   // Shared bus drive enable.
    input  wire logic              readDirIn,            // Direction level.
    output logic                   readDirOut,           // Direction drive value.
    output logic                   readDirOe,            // Direction drive enable.
    input  wire logic              dataStrobeIn,         // Strobe level.
    output logic                   dataStrobeOut,        // Strobe drive value.
    output logic                   dataStrobeOe,         // Strobe drive enable.
    output logic                   xcvrInboundCtl,       // Inbound transceiver control.
    output logic                   xcvrInboundOe,        // Its drive enable.
    output logic                   xcvrOutboundCtl,      // Outbound transceiver control.
    output logic                   xcvrOutboundOe,       // Its drive enable.
    input  wire logic              burstReleaseIn,       // Configurable pin level.
    output logic                   byteMaskLow,          // Configurable pin drive value.
    output logic                   byteMaskLowOe,        // Configurable pin drive enable.
    output logic                   byteMaskHigh,         // Companion pin drive value.
    output logic                   byteMaskHighOe,       // Companion pin drive enable.
    output logic                   attentionIrq_b,       // Open-drain level, always low.
    output logic                   attentionIrqOe        // Pulls the line low when high.
);

    // ************************************************************
    // State.
    // ************************************************************
    hbp_state_t        state_r;
    hbp_state_t        state_nxt;
    hbp_req_t          cmd_r;
    logic              master;
    logic              slaveIdle;
    logic              pinIsInput;
    logic              releasePend_r;
    logic              strobeIn_r;
    logic [DATA_W-1:0] busOut_r;

    // Mode bits picked out of the control words.
    assign pinIsInput = controlStatusFour[PIN_IN_BIT];
    assign master     = (state_r != S_IDLE);
    assign slaveIdle  = !master && slaveSel;

    // Requests are taken when idle, or right after a transfer unless a release is pending.
    assign dmaReady = dmaReq && (state_r == S_IDLE || (state_r == S_DONE && !releasePend_r));

    // Next state of the master sequence.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (dmaReady) begin
                    state_nxt = S_ADDR;
                end
            end
            S_ADDR: state_nxt = S_DATA;
            S_DATA: state_nxt = S_DONE;
            S_DONE: begin
                state_nxt = dmaReady ? S_ADDR : S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Request capture when a transfer is taken.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_r <= '0;
        end else if (dmaReady) begin
            cmd_r <= dmaCmd;
        end
    end

    // Release request is held until the current transfer completes.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            releasePend_r <= 1'b0;
        end else if (state_r == S_DONE) begin
            // A release met while closing an uncut transfer is kept for the next one.
            releasePend_r <= !releasePend_r && pinIsInput && burstReleaseIn;
        end else if (master && pinIsInput && burstReleaseIn) begin
            releasePend_r <= 1'b1;
        end
    end

    // Shared bus drive register: address, write data or slave read word.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busOut_r <= BUS_RST;
        end else if (dmaReady) begin
            busOut_r <= dmaCmd.addr;
        end else if (state_r == S_ADDR) begin
            busOut_r <= cmd_r.wrData;
        end else if (slaveIdle && readDirIn) begin
            busOut_r <= slaveRdData;
        end
    end

    // Master read sample at the strobe rising edge, and completion pulses.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dmaRdData <= BUS_RST;
            dmaDone   <= 1'b0;
            burstCut  <= 1'b0;
        end else begin
            dmaDone  <= (state_r == S_DATA);
            burstCut <= (state_r == S_DONE) && releasePend_r;
            if (state_r == S_DATA && cmd_r.isRead) begin
                dmaRdData <= muxedAddrDataBusIn;
            end
        end
    end

    // Slave write capture on the rising edge of the host's strobe.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobeIn_r    <= STROBE_IDLE;
            slaveWrStrobe <= 1'b0;
            slaveWrData   <= BUS_RST;
        end else begin
            strobeIn_r    <= dataStrobeIn;
            slaveWrStrobe <= 1'b0;
            if (slaveIdle && !readDirIn && dataStrobeIn && !strobeIn_r) begin
                slaveWrStrobe <= 1'b1;
                slaveWrData   <= muxedAddrDataBusIn;
            end
        end
    end

    // Attention interrupt, registered so the pin never glitches.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            attentionIrqOe <= 1'b0;
        end else begin
            attentionIrqOe <= controlStatusZero[IRQ_EN_BIT] && (|statusFlags);
        end
    end
    assign attentionIrq_b = 1'b0;

    // Shared bus enables: master drives the address phase and whole writes, slave drives on reads.
    assign muxedAddrDataBusOut = busOut_r;
    assign muxedAddrDataBusOe  = (state_r == S_ADDR) || (master && !cmd_r.isRead)
                               || (slaveIdle && readDirIn);

    // Direction and strobe: driven as master only, strobe low through data phase.
    assign readDirOut    = cmd_r.isRead;
    assign readDirOe     = master;
    assign dataStrobeOut = (state_r != S_DATA);
    assign dataStrobeOe  = master;

    // Transceiver controls.
    assign xcvrInboundCtl  = (state_r == S_DATA) && cmd_r.isRead;
    assign xcvrInboundOe   = master;
    assign xcvrOutboundCtl = (state_r == S_ADDR) || !cmd_r.isRead;
    assign xcvrOutboundOe  = master;

    // Byte-select pins: active-low mask, or the byte line when bus config is set.
    always_comb begin
        if (controlStatusFour[BUS_CFG_BIT]) begin
            byteMaskLow  = !(&cmd_r.byteEn);
            byteMaskHigh = 1'b1;
        end else begin
            byteMaskLow  = !cmd_r.byteEn[0];
            byteMaskHigh = !cmd_r.byteEn[1];
        end
    end
    assign byteMaskLowOe  = master && !pinIsInput;
    assign byteMaskHighOe = master && !controlStatusFour[BUS_CFG_BIT];

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_irq_on;
        (controlStatusZero[IRQ_EN_BIT] && |statusFlags) |=> attentionIrqOe;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("Interrupt not raised.");
    property p_irq_gate;
        !$past(controlStatusZero[IRQ_EN_BIT]) |-> !attentionIrqOe;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("Interrupt while disabled.");
    property p_addr;
        dmaReady |=> muxedAddrDataBusOe && muxedAddrDataBusOut == $past(dmaCmd.addr);
    endproperty
    a_addr: assert property (p_addr) else $error("Address phase wrong.");
    property p_wdata;
        (state_r == S_ADDR && !cmd_r.isRead) |=> (muxedAddrDataBusOut == cmd_r.wrData) [*2];
    endproperty
    a_wdata: assert property (p_wdata) else $error("Write data not held.");
    property p_dir;
        (dmaReady ##1 1'b1 [*3]) |-> readDirOe && readDirOut == $past(dmaCmd.isRead, 3);
    endproperty
    a_dir: assert property (p_dir) else $error("Direction not held.");
    property p_float;
        (!master && !slaveSel) |-> !muxedAddrDataBusOe && !dataStrobeOe && !readDirOe
            && !byteMaskLowOe && !byteMaskHighOe;
    endproperty
    a_float: assert property (p_float) else $error("Outputs not released.");
    property p_inbound;
        (xcvrInboundOe && xcvrInboundCtl) |-> cmd_r.isRead && !muxedAddrDataBusOe;
    endproperty
    a_inbound: assert property (p_inbound) else $error("Inbound control misused.");
    property p_strobe;
        (state_r == S_DATA) |-> !dataStrobeOut ##1 dataStrobeOut && dmaDone;
    endproperty
    a_strobe: assert property (p_strobe) else $error("Strobe edge wrong.");
    property p_release;
        (state_r == S_DONE && releasePend_r) |=> state_r == S_IDLE && burstCut;
    endproperty
    a_release: assert property (p_release) else $error("Burst not ended.");
    property p_slave_rd;
        (slaveIdle && readDirIn) |=> muxedAddrDataBusOut == $past(slaveRdData);
    endproperty
    a_slave_rd: assert property (p_slave_rd) else $error("Slave read data wrong.");

    c_read: cover property (dmaReady && dmaCmd.isRead ##3 dmaDone);
    c_write: cover property (dmaReady && !dmaCmd.isRead ##3 dmaDone);
    c_slave_wr: cover property (slaveWrStrobe);
    c_cut: cover property (burstCut);

endmodule

// ### verilog/hbp_pkg.sv
// Notes on behaviour
// - Address phase puts the low 16 address bits on the shared bus.
// - Data phase carries the word; the transfer type picks the driver.
// - Direction is driven only as master, valid all transaction, else released.
// - As slave, direction high means device drives; low means device captures.
// - As master, direction low when writing out, high when reading in.
// - Attention interrupt asserts when any of five status flags is set.
// - Attention interrupt asserts only while the enable bit 09 is one.
// - Inbound transceiver control only in master read data phase, never in writes.
// - Outbound control while master drives: read address phase, whole write.
// - Driven data is stable at the strobe's rising edge, where it is sampled.
// - Device drives strobe as master, takes it as slave, else released.
// - Register-four bit 06 set: pin is burst release, ending burst after transfer.
// - Register-four bit 06 clear: pin is a byte-select output like its companion.
// - Bus-config bit clear: pins give byte mask, low/low whole word.
// - Byte-select outputs are driven only as master, ignored as slave.
package hbp_pkg;

    // ************************************************************
    // Widths, control bit positions and reset values.
    // ************************************************************
    localparam int              DATA_W        = 16;
    localparam int              IRQ_EN_BIT    = 9;
    localparam int              PIN_IN_BIT    = 6;
    localparam int              BUS_CFG_BIT   = 0;
    localparam logic [15:0]     BUS_RST       = 16'h0000;
    localparam logic            STROBE_IDLE   = 1'h1;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_ADDR = 2'b01,
        S_DATA = 2'b10,
        S_DONE = 2'b11
    } hbp_state_t;

    typedef struct packed {
        logic missedFrame;
        logic memoryError;
        logic receiveDone;
        logic transmitDone;
        logic fifthEvent;
    } hbp_flags_t;

    typedef struct packed {
        logic              isRead;
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic [1:0]        byteEn;
    } hbp_req_t;

endpackage

// ### sim/hbp_host_model.sv
module hbp_host_model
    import hbp_pkg::*;
(
    input  wire logic              clk,      // System clock.
    input  wire logic              rst_b,    // Reset, active low.
    input  wire logic [DATA_W-1:0] busLvl,   // Resolved shared bus.
    input  wire logic              strobe,   // Resolved strobe level.
    input  wire logic              strobeOe, // Device drives the strobe.
    input  wire logic              readDir,  // Resolved direction level.
    output logic [DATA_W-1:0]      hostBus   // Host drive value on the bus.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] mem [16];
    logic [3:0]        addr_r;
    logic              stb_r;
    logic              oe_r;
    logic [DATA_W-1:0] last_r;
    logic              drive;

    // Memory answers in the low strobe half of a read, else shows a changing pattern.
    assign drive   = strobeOe && !strobe && readDir;
    assign hostBus = drive ? mem[addr_r] : ~last_r;

    // Address is latched as a cycle opens; writes land at the strobe rising edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_r <= 4'h0;
            stb_r  <= 1'h1;
            oe_r   <= 1'h0;
            last_r <= 16'h0000;
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 16'h5a00 + 16'(i);
            end
        end else begin
            stb_r  <= strobe;
            oe_r   <= strobeOe;
            last_r <= hostBus;
            if (strobeOe && !oe_r) begin
                addr_r <= busLvl[3:0];
            end
            if (strobeOe && strobe && !stb_r && !readDir) begin
                mem[addr_r] <= busLvl;
            end
        end
    end
endmodule

// ### sim/tb_top.sv
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top
    import hbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        hbp_req_t    cmd;
        logic [15:0] expRd;
        logic [1:0]  expMask;
    } hbp_row_t;
    logic clk, rst_b, dmaReq, dmaReady, dmaDone, burstCut, slaveSel, slvWr, tbBusOe, tbDir, tbStb;
    logic tbRel, busOe, dirOut, dirOe, stbOut, stbOe, inb, outb, bmLo, bmLoOe, bmHi, bmHiOe, irqOe;
    logic inbOe, outbOe, irqPin_b;
    logic [15:0] cs0, cs4, rdData, slvRd, slvWrData, busOut, tbBus, hostBus;
    hbp_flags_t flags;
    hbp_req_t   cmd;
    int         n_mismatch = 0;
    int         tests_run = 0;
    wire [15:0] busLvl = busOe ? busOut : (tbBusOe ? tbBus : hostBus);
    wire        dirLvl = dirOe ? dirOut : tbDir;
    wire        stbLvl = stbOe ? stbOut : tbStb;
    wire        relLvl = bmLoOe ? bmLo : tbRel;
    hbp_row_t   rows [6] = '{
        '{'{1'h0, 16'h0001, 16'h1234, 2'h3}, 16'h0000, 2'h0},
        '{'{1'h1, 16'h0001, 16'h0000, 2'h3}, 16'h1234, 2'h0},
        '{'{1'h0, 16'h0002, 16'habcd, 2'h1}, 16'h0000, 2'h2},
        '{'{1'h1, 16'h0002, 16'h0000, 2'h2}, 16'habcd, 2'h1},
        '{'{1'h0, 16'h000f, 16'hffff, 2'h0}, 16'h0000, 2'h3},
        '{'{1'h1, 16'h000f, 16'h0000, 2'h3}, 16'hffff, 2'h0}};

    hbp_host_port u_hbp_host_port (.clk(clk), .rst_b(rst_b), .controlStatusZero(cs0),
        .controlStatusFour(cs4), .statusFlags(flags), .dmaReq(dmaReq), .dmaCmd(cmd),
        .dmaReady(dmaReady), .dmaDone(dmaDone), .dmaRdData(rdData), .burstCut(burstCut),
        .slaveSel(slaveSel), .slaveRdData(slvRd), .slaveWrStrobe(slvWr),
        .slaveWrData(slvWrData), .muxedAddrDataBusIn(busLvl), .muxedAddrDataBusOut(busOut),
        .muxedAddrDataBusOe(busOe), .readDirIn(dirLvl), .readDirOut(dirOut), .readDirOe(dirOe),
        .dataStrobeIn(stbLvl), .dataStrobeOut(stbOut), .dataStrobeOe(stbOe),
        .xcvrInboundCtl(inb), .xcvrInboundOe(inbOe), .xcvrOutboundCtl(outb),
        .xcvrOutboundOe(outbOe), .burstReleaseIn(relLvl), .byteMaskLow(bmLo),
        .byteMaskLowOe(bmLoOe), .byteMaskHigh(bmHi), .byteMaskHighOe(bmHiOe),
        .attentionIrq_b(irqPin_b), .attentionIrqOe(irqOe));
    hbp_host_model u_hbp_host_model (.clk(clk), .rst_b(rst_b), .busLvl(busLvl),
        .strobe(stbLvl), .strobeOe(stbOe), .readDir(dirLvl), .hostBus(hostBus));

    // Clock of 10 ns period.
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One master transfer, checked phase by phase at the falling edges.
    task automatic master(input hbp_row_t r);
        int k;
        k = 0;
        @(posedge clk);
        dmaReq <= 1'h1;
        cmd    <= r.cmd;
        do begin
            @(negedge clk);
            k++;
        end while (dmaReady !== 1'h1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            give_verdict();
        end
        @(posedge clk);
        dmaReq <= 1'h0;
        @(negedge clk);
        `CHK("address", r.cmd.addr, busLvl)
        `CHK("dir", {1'h1, r.cmd.isRead}, {dirOe, dirLvl})
        `CHK("outbound", 1'h1, outb)
        `CHK("xcvrOe", 2'h3, {inbOe, outbOe})
        `CHK("maskOe", {1'h1, ~cs4[6]}, {bmHiOe, bmLoOe})
        `CHK("maskHi", r.expMask[1], bmHi)
        `CHK("maskLo", r.expMask[0], bmLo)
        @(negedge clk);
        `CHK("strobe", 2'h2, {stbOe, stbLvl})
        `CHK("xcvr", {r.cmd.isRead, ~r.cmd.isRead}, {inb, outb})
        `CHK("busOe", ~r.cmd.isRead, busOe)
        if (!r.cmd.isRead) `CHK("wrData", r.cmd.wrData, busLvl)
        @(negedge clk);
        `CHK("done", 1'h1, dmaDone)
        `CHK("dirHeld", r.cmd.isRead, dirLvl)
        if (r.cmd.isRead) `CHK("rdData", r.expRd, rdData)
        @(negedge clk);
        `CHK("cut", cs4[6] & tbRel, burstCut)
        `CHK("released", 3'h0, {busOe, dirOe, stbOe})
        `CHK("xcvrOff", 2'h0, {inbOe, outbOe})
    endtask

    // Reset, table loop, then slave, release and interrupt cases.
    initial begin
        {rst_b, dmaReq, slaveSel, tbBusOe, tbDir, tbRel} = 6'h0;
        tbStb = 1'h1;
        {cs0, cs4, slvRd, tbBus} = 64'h0;
        flags = 5'h00;
        cmd   = '0;
        repeat (10) @(posedge clk);
        `CHK("resetOe", 4'h0, {busOe, dirOe, stbOe, bmHiOe})
        rst_b <= 1'h1;
        foreach (rows[i]) master(rows[i]);
        $display("table rows done");
        @(posedge clk);
        {slaveSel, tbDir} <= 2'h3;
        slvRd <= 16'hc3a5;
        @(negedge clk);
        `CHK("slvOe", 1'h1, busOe)
        @(negedge clk);
        `CHK("slvRd", 16'hc3a5, busLvl)
        `CHK("slvPins", 3'h0, {dirOe, stbOe, bmHiOe})
        @(posedge clk);
        {tbDir, tbStb, tbBusOe} <= 3'h1;
        tbBus <= 16'h6b1e;
        @(posedge clk);
        tbStb <= 1'h1;
        @(negedge clk);
        `CHK("slvWrOe", 1'h0, busOe)
        @(negedge clk);
        `CHK("slvWr", 17'h16b1e, {slvWr, slvWrData})
        @(posedge clk);
        {slaveSel, tbBusOe} <= 2'h0;
        $display("slave test done");
        cs4   <= 16'h0040;
        tbRel <= 1'h1;
        master(rows[0]);
        @(posedge clk);
        cs4   <= 16'h0000;
        tbRel <= 1'h0;
        $display("release test done");
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            cs0   <= (i < 6) ? 16'h0200 : 16'h0000;
            flags <= (i < 5) ? 5'(5'h10 >> i) : ((i == 5) ? 5'h00 : 5'h1f);
            @(posedge clk);
            @(negedge clk);
            `CHK("irq", i < 5, irqOe)
            `CHK("irqPin", 1'h0, irqPin_b)
        end
        $display("interrupt test done");
        give_verdict();
    end
endmodule
